// File: common/scm_consts.vh
`ifndef SCM_CONSTS_VH
`define SCM_CONSTS_VH

// ----------------------------------------
// strap lane positions
// ----------------------------------------
`define SCM_CFG_WIDTH 20
`define SCM_CFG_REVERSE_BIT 2
`define SCM_CFG_PRIVACY_BIT 3
`define SCM_CFG_SPLIT_LO 5
`define SCM_CFG_SPLIT_HI 6

// ----------------------------------------
// split encodings
// ----------------------------------------
`define SCM_SPLIT_X8_2X4 2'h0
`define SCM_SPLIT_RSVD 2'h1
`define SCM_SPLIT_2X8 2'h2
`define SCM_SPLIT_X16 2'h3

// ----------------------------------------
// reset values and thermal trip threshold
// ----------------------------------------
`define SCM_CFG_RESET 20'hFFFFF
`define SCM_TRIP_TEMP_C 8'h82

`endif

// File: hw/scm_strap_config.v
`timescale 1ns/10ps
`include "scm_consts.vh"
module scm_strap_config (
    // clock and reset
    input wire clk_in,
    input wire resetn_in,
    // pins from the board and companion chip
    input wire platform_resetn_in,
    input wire platform_power_sync_in,
    input wire [`SCM_CFG_WIDTH-1:0] cfg_strap_in,
    input wire [`SCM_CFG_WIDTH-1:0] cfg_strap_driven_in,
    // internal events
    input wire [7:0] junction_temp_in,
    input wire power_fault_in,
    input wire memory_reset_req_in,
    // decoded settings
    output reg lane_reverse_out,
    output reg debug_override_out,
    output reg [1:0] port_split_out,
    output reg split_reserved_out,
    output reg [`SCM_CFG_WIDTH-1:0] cfg_latched_out,
    // status pins
    output reg power_sync_out,
    output reg thermal_trip_out,
    output reg power_delivery_fault_out,
    output reg halt_execution_out,
    output reg memory_reset_out
);

// ----------------------------------------
// synchronisers
// ----------------------------------------
// every board pin crosses two flops before anything reads it
localparam [`SCM_CFG_WIDTH-1:0] CFG_RESET = `SCM_CFG_RESET;
localparam [`SCM_CFG_WIDTH-1:0] DRV_RESET = 20'h00000;

reg [`SCM_CFG_WIDTH-1:0] cfg_s1_q;
reg [`SCM_CFG_WIDTH-1:0] cfg_s2_q;
reg [`SCM_CFG_WIDTH-1:0] drv_s1_q;
reg [`SCM_CFG_WIDTH-1:0] drv_s2_q;
reg [1:0] prst_q;
reg [1:0] sync_q;
wire [`SCM_CFG_WIDTH-1:0] cfg_eff_d;
wire in_reset;

// ----------------------------------------
// decode helpers
// ----------------------------------------
// undriven lanes float high via on-die pull-up
function strap_level;
    input level;
    input driven;
    begin
        strap_level = level | ~driven;
    end
endfunction

// split code is read as one pair, upper lane the msb
function [1:0] split_code;
    input [`SCM_CFG_WIDTH-1:0] cfg;
    begin
        split_code = cfg[`SCM_CFG_SPLIT_HI:`SCM_CFG_SPLIT_LO];
    end
endfunction

function split_is_reserved;
    input [1:0] code;
    begin
        split_is_reserved = (code == `SCM_SPLIT_RSVD);
    end
endfunction

// ----------------------------------------
// per-lane strap synchronisers
// ----------------------------------------
// lanes settle independently; a lane caught mid-change only
// matters while platform reset is low, where it is re-read
genvar g;
generate
    for (g = 0; g < `SCM_CFG_WIDTH; g = g + 1) begin : g_lane
        always @(posedge clk_in) begin
            if (!resetn_in) begin
                cfg_s1_q[g] <= CFG_RESET[g];
                cfg_s2_q[g] <= CFG_RESET[g];
                drv_s1_q[g] <= DRV_RESET[g];
                drv_s2_q[g] <= DRV_RESET[g];
            end else begin
                cfg_s1_q[g] <= cfg_strap_in[g];
                cfg_s2_q[g] <= cfg_s1_q[g];
                drv_s1_q[g] <= cfg_strap_driven_in[g];
                drv_s2_q[g] <= drv_s1_q[g];
            end
        end

        assign cfg_eff_d[g] = strap_level(cfg_s2_q[g], drv_s2_q[g]);
    end
endgenerate

// ----------------------------------------
// platform pin synchronisers
// ----------------------------------------
// clearing to zero means local reset counts as platform reset for two cycles, while the strap
// flops still hold their reset values, so straps reload as SCM_CFG_RESET, not from the pins
always @(posedge clk_in) begin
    if (!resetn_in) begin
        prst_q <= 2'h0;
        sync_q <= 2'h0;
    end else begin
        prst_q <= {prst_q[0], platform_resetn_in};
        sync_q <= {sync_q[0], platform_power_sync_in};
    end
end

// companion chip owns the platform reset pin
assign in_reset = ~prst_q[1];

// ----------------------------------------
// strap capture and decode
// ----------------------------------------
reg [`SCM_CFG_WIDTH-1:0] cfg_latched_d;
reg lane_reverse_d;
reg debug_override_d;
reg [1:0] port_split_d;
reg split_reserved_d;

// tracking only while reset is low keeps settings stable at run time
always @* begin
    cfg_latched_d = cfg_latched_out;
    lane_reverse_d = lane_reverse_out;
    debug_override_d = debug_override_out;
    port_split_d = port_split_out;
    split_reserved_d = split_reserved_out;
    if (in_reset) begin
        cfg_latched_d = cfg_eff_d;
        lane_reverse_d = ~cfg_eff_d[`SCM_CFG_REVERSE_BIT];
        debug_override_d = ~cfg_eff_d[`SCM_CFG_PRIVACY_BIT];
        port_split_d = split_code(cfg_eff_d);
        split_reserved_d = split_is_reserved(split_code(cfg_eff_d));
    end
end

always @(posedge clk_in) begin
    if (!resetn_in) begin
        cfg_latched_out <= `SCM_CFG_RESET;
        lane_reverse_out <= 1'b0;
        debug_override_out <= 1'b0;
        port_split_out <= `SCM_SPLIT_X16;
        split_reserved_out <= 1'b0;
    end else begin
        cfg_latched_out <= cfg_latched_d;
        lane_reverse_out <= lane_reverse_d;
        debug_override_out <= debug_override_d;
        port_split_out <= port_split_d;
        split_reserved_out <= split_reserved_d;
    end
end

// ----------------------------------------
// thermal and power fault
// ----------------------------------------
reg over_temp_d;
reg trip_d;
reg fault_d;
reg mem_reset_d;

// trip is sticky until reset: the part has shut itself down
// power fault forces a trip so both pins read together
always @* begin
    over_temp_d = (junction_temp_in > `SCM_TRIP_TEMP_C);
    trip_d = thermal_trip_out | over_temp_d | power_fault_in;
    fault_d = power_delivery_fault_out | power_fault_in;
    mem_reset_d = in_reset | memory_reset_req_in;
end

// ----------------------------------------
// status registers
// ----------------------------------------
// memory reset comes up asserted so the drams stay quiet
// until platform reset has been seen high
always @(posedge clk_in) begin
    if (!resetn_in) begin
        thermal_trip_out <= 1'b0;
        halt_execution_out <= 1'b0;
        power_delivery_fault_out <= 1'b0;
        power_sync_out <= 1'b0;
        memory_reset_out <= 1'b1;
    end else begin
        thermal_trip_out <= trip_d;
        halt_execution_out <= trip_d;
        power_delivery_fault_out <= fault_d;
        power_sync_out <= sync_q[1];
        // one pin for all channels: no per-channel reset exists
        memory_reset_out <= mem_reset_d;
    end
end

endmodule // scm_strap_config

// File: sim/scm_checker.sv
`timescale 1ns/10ps
module scm_checker (input clk_in, resetn_in, platform_resetn_in, power_fault_in, memory_reset_req_in, lane_reverse_out,
    debug_override_out, split_reserved_out, thermal_trip_out, power_delivery_fault_out, halt_execution_out,
    memory_reset_out, input [7:0] junction_temp_in, input [1:0] port_split_out, input [19:0] cfg_latched_out);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    AST_PF: assert property (power_fault_in |=> power_delivery_fault_out && thermal_trip_out)
        else $error("fault pins low");
    AST_TT: assert property (junction_temp_in > 8'h82 |=> thermal_trip_out && halt_execution_out)
        else $error("no trip");
    AST_ST: assert property (thermal_trip_out |=> thermal_trip_out) else $error("trip lost");
    AST_HL: assert property (halt_execution_out == thermal_trip_out) else $error("halt");
    AST_MQ: assert property (memory_reset_req_in |=> memory_reset_out) else $error("mem req");
    AST_LR: assert property (lane_reverse_out != cfg_latched_out[2]) else $error("reverse");
    AST_DO: assert property (debug_override_out != cfg_latched_out[3]) else $error("privacy");
    AST_PS: assert property (port_split_out == cfg_latched_out[6:5] &&
        split_reserved_out == (port_split_out == 2'h1)) else $error("split");
    AST_MR: assert property (!platform_resetn_in [*3] |=> memory_reset_out) else $error("mem reset");
    AST_HD: assert property (platform_resetn_in [*4] |=> $stable(cfg_latched_out)) else $error("moved");
    cover property (split_reserved_out); cover property (power_fault_in); cover property (!lane_reverse_out);
endmodule // scm_checker

// File: sim/scm_partner.sv
`timescale 1ns/10ps
module scm_partner (input clk_in, output logic platform_resetn_in = 0, platform_power_sync_in = 0,
    output logic [19:0] cfg_strap_in = 20'h00000, cfg_strap_driven_in = 20'h00000);
    // unterminated lanes show the inverse, so a decoded one never comes from the pin
    task drive(input logic r, input logic [19:0] v, m);
        @(posedge clk_in) #1 platform_resetn_in = r;
        platform_power_sync_in = ~platform_power_sync_in;
        cfg_strap_in = v & m | ~v & ~m;
        cfg_strap_driven_in = m;
    endtask
endmodule // scm_partner

// File: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk_in = 0, resetn_in = 0, power_fault_in = 0, memory_reset_req_in = 0, platform_resetn_in;
    logic platform_power_sync_in, lane_reverse_out, debug_override_out, split_reserved_out, power_sync_out;
    logic thermal_trip_out, power_delivery_fault_out, halt_execution_out, memory_reset_out;
    logic [1:0] port_split_out;
    logic [7:0] junction_temp_in = 8'h00;
    logic [19:0] cfg_strap_in, cfg_strap_driven_in, cfg_latched_out, v, m, e;
    int n_fail = 0, total_checks = 0, cyc = 0;
    scm_strap_config scm_strap_config_i (.*);
    scm_partner scm_partner_i (.*);
    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) if (++cyc > 300) begin n_fail++; tally_and_finish(); end
    task chk(string n, logic [31:0] s, x);
        total_checks++;
        if (s !== x) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, x, s); end
    endtask
    task tally_and_finish;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(22413));
        #36 resetn_in = 1;
        // pass 0 leaves every lane open; later passes walk all four split codes
        for (int i = 0; i < 8; i++) begin
            v = 20'($urandom) & ~20'h00060 | 20'(i % 4) << 5;
            m = (i == 0) ? 20'h00000 : 20'($urandom) | 20'h00060;
            e = v | ~m;
            scm_partner_i.drive(0, v, m);
            #30 chk("decode", {cfg_latched_out, lane_reverse_out, debug_override_out, port_split_out,
                split_reserved_out, memory_reset_out},
                {e, !e[2], !e[3], e[6:5], e[6:5] == 2'h1, 1'b1});
        end
        scm_partner_i.drive(1, v, m);
        #20 scm_partner_i.drive(1, ~v, 20'hFFFFF);
        #40 chk("hold", {cfg_latched_out, memory_reset_out, power_sync_out},
            {e, 1'b0, platform_power_sync_in});
        junction_temp_in = 8'h82;
        memory_reset_req_in = 1;
        #10 chk("no_trip", thermal_trip_out, 0);
        chk("mem_req", memory_reset_out, 1);
        junction_temp_in = 8'h83 + 8'($urandom % 124);
        memory_reset_req_in = 0;
        #10 chk("trip", {thermal_trip_out, halt_execution_out, power_delivery_fault_out,
            memory_reset_out}, 4'hC);
        resetn_in = 0;
        junction_temp_in = 8'h00;
        #10 resetn_in = 1;
        power_fault_in = 1;
        #10 power_fault_in = 0;
        chk("fault", {thermal_trip_out, power_delivery_fault_out}, 2'h3);
        tally_and_finish();
    end
endmodule // testbench
bind scm_strap_config scm_checker scm_checker_i (.*);
